// ---- inc/acced_pkg.sv ----
// constants and carrier types for the gain clamp and carrier error detect slice
package acced_pkg;

  // --------------------------------------------------------------------------
  // datapath widths
  // --------------------------------------------------------------------------
  localparam int ACC_W   = 16;                // gain accumulator width
  localparam int GAIN_W  = 8;                 // gain byte taken from the accumulator top
  localparam int GERR_W  = 8;                 // signed gain step fed to the accumulator
  localparam int PH_W    = 8;                 // phase word, one full turn is 2**PH_W
  localparam int POFF_W  = 4;                 // phase offset, units of pi/8
  localparam int FOFF_W  = 5;                 // frequency offset, top bits of the result
  localparam int DLY_K_MAX = 4;               // largest usable delay exponent
  localparam int FSH_MAX = 4;                 // largest usable frequency shift

  // --------------------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 8;                  // byte address
  localparam int DATA_W = 32;
  localparam logic [5:0] IDX_LIMITS = 6'h02;  // gain_control_limits
  localparam logic [5:0] IDX_PHASE  = 6'h03;  // carrier_phase_detector_control
  localparam logic [5:0] IDX_DISC   = 6'h04;  // discriminator_control
  localparam logic [5:0] IDX_FREQ   = 6'h05;  // frequency_error_detector_control
  localparam logic [5:0] IDX_STATUS = 6'h08;  // read-only block state

  // field positions
  localparam int LIM_UP_LSB = 8;              // upper limit in bits 15-8
  localparam int LIM_LO_LSB = 0;              // lower limit in bits 7-0
  localparam int POFF_LSB   = 2;              // phase offset in bits 5-2
  localparam int PSH_LSB    = 0;              // phase shift in bits 1-0
  localparam int DLY_LSB    = 0;              // delay exponent in bits 2-0
  localparam int FOFF_LSB   = 3;              // frequency offset in bits 7-3
  localparam int FSH_LSB    = 0;              // frequency shift in bits 2-0

  // values after reset
  localparam logic [7:0]       RST_UPPER = 8'hff;   // clamp open at the top
  localparam logic [7:0]       RST_LOWER = 8'h00;   // clamp open at the bottom
  localparam logic [7:0]       RST_CTRL  = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACC   = 16'h0000;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [GERR_W-1:0] gain_err;              // signed step for the accumulator
    logic [PH_W-1:0]   phase;                 // converter phase, one turn = 2**PH_W
  } acced_sample_type;

  typedef struct packed {
    logic [1:0]        gain_exp;              // exponent bits of the gain byte
    logic [5:0]        gain_man;              // mantissa bits of the gain byte
    logic [PH_W-1:0]   phase_err;             // offset and shifted phase
    logic [PH_W-1:0]   freq_err;              // offset and shifted frequency
  } acced_result_type;

endpackage : acced_pkg

// ---- verilog/acced_core.sv ----
// gain clamp, phase error and frequency error datapath slice with register port
`timescale 1ns/1ps
`default_nettype none

// Operation
// - gain comes from the top eight bits of the gain accumulator
// - sum above upper limit loads the accumulator with the upper limit
// - sum below lower limit loads the accumulator with the lower limit
// - each limit byte is two exponent bits then six mantissa bits, msb first
// - equal upper and lower limits hold the gain fixed at that value
// - phase offset is added modulo one turn to the converter phase
// - phase offset is a four-bit signed fraction of pi, 22.5 degree steps
// - phase error shifts left zero to three places, zeros fill from below
// - frequency is current phase minus phase delayed by two to the K
// - delay line supports one, two, four, eight and sixteen samples
// - frequency offset is added with wraparound to the discriminator output
// - frequency offset is a five-bit signed fraction from 0.9375 to -1.0
// - frequency offset lands on the top five bits, lower bits pass through
// - frequency error shifts left zero to four places by a three-bit field
module acced_core #(
  parameter int DLY_K_MAX = acced_pkg::DLY_K_MAX  // largest delay exponent
) (
  input  wire logic                           i_clock,   // 250 MHz system clock
  input  wire logic                           i_rst_n,   // async reset, active low
  input  wire logic [acced_pkg::ADDR_W-1:0]   i_addr,    // register byte address
  input  wire logic [acced_pkg::DATA_W-1:0]   i_wdata,   // register write data
  input  wire logic                           i_wr,      // write strobe
  input  wire logic                           i_rd,      // read strobe
  output logic      [acced_pkg::DATA_W-1:0]   o_rdata,   // read data, one cycle later
  input  wire logic                           i_valid,   // sample offered
  input  wire acced_pkg::acced_sample_type    i_sample,  // gain step and phase
  output logic                                o_ready,   // sample can be taken
  output logic                                o_valid,   // result offered
  output acced_pkg::acced_result_type         o_result,  // gain and error words
  input  wire logic                           i_ready    // receiver takes result
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  localparam int DLY_N  = 1 << DLY_K_MAX;     // delay line depth
  localparam int SUM_W  = acced_pkg::ACC_W + 2;
  localparam int PH_W   = acced_pkg::PH_W;

  typedef struct packed {
    logic [7:0]                       upper;     // upper gain limit byte
    logic [7:0]                       lower;     // lower gain limit byte
    logic [7:0]                       ph_ctrl;   // phase detector control
    logic [7:0]                       disc_ctrl; // discriminator control
    logic [7:0]                       fr_ctrl;   // frequency detector control
    logic [acced_pkg::ACC_W-1:0]      acc;       // gain accumulator
    logic [DLY_N-1:0][PH_W-1:0]       hist;      // past phases, entry 0 newest
    logic                             out_v;     // output stage full
    acced_pkg::acced_result_type      out;       // output stage
    logic                             skid_v;    // second entry full
    acced_pkg::acced_result_type      skid;      // second entry
    logic                             ready;     // room for one more sample
    logic                             hit_hi;    // last sample hit the upper limit
    logic                             hit_lo;    // last sample hit the lower limit
    logic [acced_pkg::DATA_W-1:0]     rdata;     // read answer
  } acced_state_type;

  acced_state_type st_q;
  acced_state_type st_d;

  // --------------------------------------------------------------------------
  // datapath terms
  // --------------------------------------------------------------------------
  logic                                push;          // sample taken this cycle
  logic                                pop;           // result taken this cycle
  logic signed [SUM_W-1:0]             gsum;          // accumulator plus step
  logic signed [SUM_W-1:0]             hi_bound;      // largest sum inside the clamp
  logic signed [SUM_W-1:0]             lo_bound;      // smallest sum inside the clamp
  logic        [acced_pkg::ACC_W-1:0]  acc_next;      // clamped accumulator
  logic                                clamp_hi;
  logic                                clamp_lo;
  logic        [PH_W-1:0]              ph_adj;        // phase plus offset
  logic        [PH_W-1:0]              ph_err;        // shifted phase error
  logic        [2:0]                   dly_k;         // delay exponent, held in range
  logic        [PH_W-1:0]              ph_old;        // delayed phase
  logic        [PH_W-1:0]              fr_raw;        // discriminator output
  logic        [PH_W-1:0]              fr_adj;        // frequency plus offset
  logic        [2:0]                   fr_sh;         // frequency shift, held in range
  logic        [PH_W-1:0]              fr_err;        // shifted frequency error
  acced_pkg::acced_result_type         res;           // result of this sample

  assign push = i_valid & st_q.ready;
  assign pop  = st_q.out_v & i_ready;

  // gain accumulator with limit clamp, two spare bits keep carry and sign
  assign gsum     = $signed({2'b00, st_q.acc})
                  + $signed({{(SUM_W-acced_pkg::GERR_W){i_sample.gain_err[acced_pkg::GERR_W-1]}},
                             i_sample.gain_err});
  assign hi_bound = $signed({2'b00, st_q.upper, 8'hff});
  assign lo_bound = $signed({2'b00, st_q.lower, 8'h00});
  assign clamp_hi = gsum > hi_bound;
  assign clamp_lo = !clamp_hi && (gsum < lo_bound);
  // equal limits leave only one legal top byte, so the gain is fixed
  always_comb begin
    if (clamp_hi) begin
      acc_next = {st_q.upper, 8'h00};
    end else if (clamp_lo) begin
      acc_next = {st_q.lower, 8'h00};
    end else begin
      acc_next = gsum[acced_pkg::ACC_W-1:0];
    end
  end

  // phase offset in pi/8 steps sits on the top four bits of the turn
  assign ph_adj = i_sample.phase
                + {st_q.ph_ctrl[acced_pkg::POFF_LSB +: acced_pkg::POFF_W],
                   {(PH_W-acced_pkg::POFF_W){1'b0}}};
  assign ph_err = PH_W'(ph_adj << st_q.ph_ctrl[acced_pkg::PSH_LSB +: 2]);

  // delay exponents past the line depth use the deepest tap
  assign dly_k  = (st_q.disc_ctrl[acced_pkg::DLY_LSB +: 3] > 3'(DLY_K_MAX))
                ? 3'(DLY_K_MAX) : st_q.disc_ctrl[acced_pkg::DLY_LSB +: 3];
  assign ph_old = st_q.hist[(5'd1 << dly_k) - 5'd1];
  assign fr_raw = i_sample.phase - ph_old;
  assign fr_adj = fr_raw
                + {st_q.fr_ctrl[acced_pkg::FOFF_LSB +: acced_pkg::FOFF_W],
                   {(PH_W-acced_pkg::FOFF_W){1'b0}}};
  // invalid shift codes saturate rather than wrap the shifter
  assign fr_sh  = (st_q.fr_ctrl[acced_pkg::FSH_LSB +: 3] > 3'(acced_pkg::FSH_MAX))
                ? 3'(acced_pkg::FSH_MAX) : st_q.fr_ctrl[acced_pkg::FSH_LSB +: 3];
  assign fr_err = PH_W'(fr_adj << fr_sh);

  // result word, gain byte split as exponent then mantissa
  always_comb begin
    res           = '0;
    res.gain_exp  = acc_next[acced_pkg::ACC_W-1 -: 2];
    res.gain_man  = acc_next[acced_pkg::ACC_W-3 -: 6];
    res.phase_err = ph_err;
    res.freq_err  = fr_err;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic wr_hit;
    logic [5:0] idx;
    wr_hit = 1'b0;
    idx    = i_addr[acced_pkg::ADDR_W-1:2];
    st_d   = st_q;

    // register writes; reserved bits in the stored control bytes steer nothing, bits above them are dropped
    wr_hit = i_wr && (i_addr[1:0] == 2'b00);
    if (wr_hit) begin
      unique case (idx)
        acced_pkg::IDX_LIMITS: begin
          st_d.upper = i_wdata[acced_pkg::LIM_UP_LSB +: 8];
          st_d.lower = i_wdata[acced_pkg::LIM_LO_LSB +: 8];
        end
        acced_pkg::IDX_PHASE:  st_d.ph_ctrl   = i_wdata[7:0];
        acced_pkg::IDX_DISC:   st_d.disc_ctrl = i_wdata[7:0];
        acced_pkg::IDX_FREQ:   st_d.fr_ctrl   = i_wdata[7:0];
        default: ;
      endcase
    end

    // read answer stands only in the cycle after the strobe
    st_d.rdata = '0;
    if (i_rd && (i_addr[1:0] == 2'b00) && (idx == acced_pkg::IDX_STATUS)) begin
      st_d.rdata = {20'h00000, st_q.hit_hi, st_q.hit_lo, st_q.skid_v, st_q.out_v,
                    st_q.acc[acced_pkg::ACC_W-1 -: 8]};
    end

    // accumulator and delay line only move with a taken sample
    if (push) begin
      st_d.acc    = acc_next;
      st_d.hit_hi = clamp_hi;
      st_d.hit_lo = clamp_lo;
      for (int i = DLY_N-1; i > 0; i--) begin
        st_d.hist[i] = st_q.hist[i-1];
      end
      st_d.hist[0] = i_sample.phase;
    end

    // two-entry buffer: a stalled receiver parks one result in the skid slot
    if (!st_q.out_v || pop) begin
      if (st_q.skid_v) begin
        st_d.out    = st_q.skid;
        st_d.out_v  = 1'b1;
        st_d.skid_v = 1'b0;
      end else begin
        st_d.out    = res;
        st_d.out_v  = push;
      end
    end else if (push) begin
      st_d.skid   = res;
      st_d.skid_v = 1'b1;
    end
    st_d.ready = !st_d.skid_v;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q           <= '0;
      st_q.upper     <= acced_pkg::RST_UPPER;
      st_q.lower     <= acced_pkg::RST_LOWER;
      st_q.ph_ctrl   <= acced_pkg::RST_CTRL;
      st_q.disc_ctrl <= acced_pkg::RST_CTRL;
      st_q.fr_ctrl   <= acced_pkg::RST_CTRL;
      st_q.acc       <= acced_pkg::RST_ACC;
      st_q.ready     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign o_rdata  = st_q.rdata;
  assign o_ready  = st_q.ready;
  assign o_valid  = st_q.out_v;
  assign o_result = st_q.out;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  acced_pkg::acced_result_type newest;        // entry most recently written
  assign newest = st_q.skid_v ? st_q.skid : st_q.out;

  gain_byte_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    push |=> {newest.gain_exp, newest.gain_man} == st_q.acc[acced_pkg::ACC_W-1 -: 8])
    else $error("gain byte differs from accumulator top");

  clamp_upper_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && gsum > $signed({2'b00, st_q.upper, 8'hff}))
      |=> st_q.acc == {$past(st_q.upper), 8'h00} && st_q.hit_hi)
    else $error("upper clamp not applied");

  clamp_lower_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && gsum < $signed({2'b00, st_q.lower, 8'h00})
          && gsum <= $signed({2'b00, st_q.upper, 8'hff}))
      |=> st_q.acc == {$past(st_q.lower), 8'h00} && st_q.hit_lo)
    else $error("lower clamp not applied");

  fixed_gain_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.upper == st_q.lower && !i_wr)
      |=> st_q.acc[acced_pkg::ACC_W-1 -: 8] == $past(st_q.upper))
    else $error("equal limits did not fix the gain");

  phase_offset_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.ph_ctrl[1:0] == 2'b00)
      |=> newest.phase_err == PH_W'($past(i_sample.phase)
                              + {$past(st_q.ph_ctrl[5:2]), 4'h0}))
    else $error("phase offset sum wrong");

  phase_shift_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.ph_ctrl[1:0] == 2'b11)
      |=> newest.phase_err[2:0] == 3'h0)
    else $error("phase shift did not zero-fill");

  disc_unit_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.disc_ctrl[2:0] == 3'h0 && st_q.fr_ctrl == 8'h00)
      ##1 (push && st_q.disc_ctrl[2:0] == 3'h0 && st_q.fr_ctrl == 8'h00)
      |=> newest.freq_err == PH_W'($past(i_sample.phase) - $past(i_sample.phase, 2)))
    else $error("unit delay discriminator wrong");

  freq_low_bits_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.fr_ctrl[2:0] == 3'h0)
      |=> newest.freq_err[2:0] == $past(fr_raw[2:0]))
    else $error("frequency offset touched low bits");

  freq_shift_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.fr_ctrl[2:0] == 3'h4)
      |=> newest.freq_err[3:0] == 4'h0)
    else $error("four-place frequency shift wrong");

  stall_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_valid && !i_ready) |=> o_valid && $stable(o_result))
    else $error("result lost under stall");

  unmapped_read_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd && i_addr[7:2] != acced_pkg::IDX_STATUS) |=> o_rdata == 32'h00000000)
    else $error("unmapped read not zero");

  // a taken sample with a free output stage answers on the next edge
  take_answer_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && (!o_valid || i_ready)) |=> o_valid)
    else $error("taken sample produced no result");

  // both entries full must close the input before a word is lost
  skid_close_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && o_valid && !i_ready) |=> !o_ready)
    else $error("input stayed open with both entries full");

  // the parked result moves up first, so the stream keeps its order
  skid_order_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_valid && i_ready && st_q.skid_v) |=> o_valid && o_result == $past(st_q.skid))
    else $error("parked result lost or reordered");

  // a drained skid slot reopens the input one edge later
  input_reopen_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_valid && i_ready && !o_ready) |=> o_ready)
    else $error("input not reopened after skid drained");

  // nothing parked and nothing offered: the output stage empties
  stage_empty_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (o_valid && i_ready && o_ready && !i_valid) |=> !o_valid)
    else $error("stale result left in the output stage");

  // read answer stands one cycle only
  read_once_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd ##1 !i_rd) |=> o_rdata == 32'h00000000)
    else $error("read answer held too long");

  // status shows the gain byte as it stood at the strobe
  status_gain_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_rd && i_addr == {acced_pkg::IDX_STATUS, 2'b00})
      |=> o_rdata[7:0] == $past(st_q.acc[15:8]))
    else $error("status gain byte wrong");

  // both limit bytes land together in one write
  write_take_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_wr && i_addr == {acced_pkg::IDX_LIMITS, 2'b00})
      |=> {st_q.upper, st_q.lower} == $past(i_wdata[15:0]))
    else $error("limit write not taken");

  // offset sum wraps in eight bits, carry dropped
  freq_offset_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.fr_ctrl[2:0] == 3'h0)
      |=> newest.freq_err == PH_W'($past(fr_raw)
                              + {$past(st_q.fr_ctrl[7:3]), 3'h0}))
    else $error("frequency offset sum wrong");

  // one place: top bit dropped, zero in from below
  phase_shift_one_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.ph_ctrl[1:0] == 2'b01)
      |=> newest.phase_err == {$past(ph_adj[6:0]), 1'b0})
    else $error("one-place phase shift wrong");

  // two places on the frequency path
  freq_shift_two_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.fr_ctrl[2:0] == 3'h2)
      |=> newest.freq_err == {$past(fr_adj[5:0]), 2'b00})
    else $error("two-place frequency shift wrong");

  // with ordered limits the gain byte never leaves the window
  gain_window_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (push && st_q.lower <= st_q.upper)
      |=> st_q.acc[15:8] <= $past(st_q.upper)
          && st_q.acc[15:8] >= $past(st_q.lower))
    else $error("gain byte outside the limits");

endmodule : acced_core

`default_nettype wire

// ---- sim/acced_sink.sv ----
// result receiver model: random back-pressure on the output stream
`timescale 1ns/1ps
`default_nettype none

module acced_sink (
  input  wire logic       i_clock,  // system clock
  input  wire logic       i_rst_n,  // async reset, active low
  input  wire logic [7:0] i_stall,  // stall chance in percent, 100 never takes
  output logic            o_ready   // result taken on this edge when high
);
  // ----------------------------------------------------------------------------
  // back-pressure
  // ----------------------------------------------------------------------------
  // a fresh draw every cycle so stalls land at every point of a transfer
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= (($urandom % 100) >= i_stall);
    end
  end
endmodule : acced_sink
`default_nettype wire

// ---- sim/acced_core_tb.sv ----
// self-checking bench: register port, integer reference model, stalled result stream
`timescale 1ns/1ps
`default_nettype none

module acced_core_tb;
  logic                           i_clock;
  logic                           i_rst_n;
  logic [7:0]                     i_addr;
  logic [31:0]                    i_wdata;
  logic                           i_wr;
  logic                           i_rd;
  logic [31:0]                    o_rdata;
  logic                           i_valid;
  acced_pkg::acced_sample_type    i_sample;
  logic                           o_ready;
  logic                           o_valid;
  acced_pkg::acced_result_type    o_result;
  logic                           i_ready;
  logic [7:0]                     stall;
  int n_errors, total_checks, cyc;
  int acc, upper, lower, poff, psh, kx, foff, fsh, sum, pe, fr, fe;
  int hist[16];
  bit hhi, hlo;
  logic [23:0] exp_q[$];

  acced_core acced_core_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_valid(i_valid),
    .i_sample(i_sample), .o_ready(o_ready), .o_valid(o_valid), .o_result(o_result),
    .i_ready(i_ready));
  acced_sink acced_sink_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_stall(stall),
    .o_ready(i_ready));

  // ----------------------------------------------------------------------------
  // clock, cycle ceiling
  // ----------------------------------------------------------------------------
  initial i_clock = 1'b0;
  always #2 i_clock = ~i_clock;
  // the sweep needs some 1000 cycles; the ceiling leaves ample slack
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------------
  // reference model: values as seen at the edge that takes each sample
  // ----------------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst_n && i_valid && o_ready) begin
      sum = acc + int'($signed(i_sample.gain_err));
      hhi = sum > (upper * 256 + 255);
      hlo = !hhi && (sum < lower * 256);
      acc = hhi ? upper * 256 : (hlo ? lower * 256 : sum);
      pe = (((i_sample.phase + poff * 16) & 255) << psh) & 255;
      fr = (i_sample.phase - hist[(1 << ((kx > 4) ? 4 : kx)) - 1]) & 255;
      fe = (((fr + foff * 8) & 255) << ((fsh > 4) ? 4 : fsh)) & 255;
      for (int j = 15; j > 0; j--) hist[j] = hist[j - 1];
      hist[0] = i_sample.phase;
      exp_q.push_back(24'((acc >> 8) * 65536 + pe * 256 + fe));
    end
    if (i_rst_n && o_valid && i_ready) begin
      if (exp_q.size() == 0) chk(32'(o_result), 32'hffffffff);
      else chk(32'(o_result), 32'(exp_q.pop_front()));
    end
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one write cycle, then a quiet cycle so the next strobe starts on a fresh step
  task automatic wr(input logic [5:0] idx, input logic [31:0] data);
    i_wr <= 1'b1;
    i_addr <= {idx, 2'b00};
    i_wdata <= data;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
    case (idx)
      acced_pkg::IDX_LIMITS: begin upper = data[15:8]; lower = data[7:0]; end
      acced_pkg::IDX_PHASE:  begin poff = data[5:2]; psh = data[1:0]; end
      acced_pkg::IDX_DISC:   kx = data[2:0];
      acced_pkg::IDX_FREQ:   begin foff = data[7:3]; fsh = data[2:0]; end
      default: ;
    endcase
  endtask : wr

  // read data stand only in the cycle after the strobe, zero the cycle after
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    i_rd <= 1'b1;
    i_addr <= {idx, 2'b00};
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    chk(o_rdata, exp);
    @(posedge i_clock);
    chk(o_rdata, 32'h0);
  endtask : rd_chk

  function automatic logic [31:0] status_exp();
    return {20'h0, hhi, hlo, 2'b00, 8'(acc >> 8)};
  endfunction : status_exp

  // offer samples back to back, each held until an edge with room
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      i_valid <= 1'b1;
      i_sample <= 16'($urandom);
      @(posedge i_clock);
      while (!o_ready) @(posedge i_clock);
    end
    i_valid <= 1'b0;
    @(posedge i_clock);
  endtask : burst

  task automatic drain();
    int w;
    w = 0;
    while (exp_q.size() != 0 && w < 500) begin
      @(posedge i_clock);
      w++;
    end
    if (w >= 500) chk(32'(exp_q.size()), 32'h0);
    @(posedge i_clock); // the last pop may share the edge that emptied the queue
  endtask : drain

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    int up, lo;
    {i_rst_n, i_wr, i_rd, i_valid, i_addr, i_wdata, i_sample} = '0;
    stall = 8'h00;
    upper = 255;
    void'($urandom(75128));
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd_chk(acced_pkg::IDX_STATUS, 32'h0);
    wr(acced_pkg::IDX_PHASE, 32'h14);
    rd_chk(acced_pkg::IDX_PHASE, 32'h0);
    rd_chk(6'h3f, 32'h0);
    $display("test reset_and_map done");
    // sweep phase shift codes 0 to 3, frequency shift codes 0 to 4 and delays 0 to 4; boundary offsets first
    for (int c = 0; c < 20; c++) begin
      lo = $urandom % 256;
      up = (lo > 252) ? 255 : lo + $urandom % 3;
      poff = (c == 0) ? 7 : (c == 1) ? 8 : $urandom % 16;
      foff = (c == 0) ? 15 : (c == 1) ? 16 : (c % 4 == 3) ? 0 : $urandom % 32;
      wr(acced_pkg::IDX_LIMITS, 32'(up * 256 + lo));
      wr(acced_pkg::IDX_PHASE, 32'(poff * 4 + c % 4));
      wr(acced_pkg::IDX_DISC, 32'(c % 5));
      wr(acced_pkg::IDX_FREQ, 32'(foff * 8 + c % 5));
      stall <= (c % 2 == 1) ? 8'd60 : 8'd0;
      burst(20);
      drain();
      rd_chk(acced_pkg::IDX_STATUS, status_exp());
    end
    $display("test config_sweep done");
    wr(acced_pkg::IDX_LIMITS, 32'h5a5a);
    burst(10);
    drain();
    rd_chk(acced_pkg::IDX_STATUS, {20'h0, hhi, hlo, 2'b00, 8'h5a});
    $display("test fixed_gain done");
    // receiver refuses everything: both entries fill and the input closes
    stall <= 8'd100;
    repeat (3) @(posedge i_clock);
    burst(2);
    chk(32'(o_ready), 32'h0);
    rd_chk(acced_pkg::IDX_STATUS, status_exp() | 32'h300);
    stall <= 8'd0;
    drain();
    chk(32'(o_valid), 32'h0);
    $display("test full_buffer done");
    wrap_up();
  end
endmodule : acced_core_tb
`default_nettype wire
